//--- pkg/csc_params.svh
`ifndef CSC_PARAMS_SVH
`define CSC_PARAMS_SVH

// Register byte offsets
`define CSC_OFF_CTRL 8'h00
`define CSC_OFF_STATUS 8'h04
`define CSC_OFF_SETUP_RS 8'h08
`define CSC_OFF_SETUP_PP 8'h0c
`define CSC_OFF_RS_CFG 8'h10
`define CSC_OFF_PP_CFG 8'h14
`define CSC_OFF_REJECTS 8'h18

// Bit positions in the held switch vector
`define CSC_SW_PROTECT 0
`define CSC_SW_AUTO 1
`define CSC_SW_LANG 2
`define CSC_SW_EXP 3
`define CSC_SW_COMM 4
`define CSC_SW_TERM 5
`define CSC_SW_CAS_PRESENT 6
`define CSC_SW_CAS_EEPROM 7
`define CSC_SW_CAS_SWITCH 8
`define CSC_SW_OLD_REV 9
`define CSC_SW_W 10

// Read-only setup word window, words 6144 to 6655
`define CSC_RO_LO 16'h1800
`define CSC_RO_HI 16'h19ff

// Default serial word fields
`define CSC_DEF_MODE 4'h0
`define CSC_DEF_START 4'h1
`define CSC_DEF_DATA 4'h7
`define CSC_DEF_PARITY_EVEN 2'h2
`define CSC_DEF_STOP_NEW 2'h2
`define CSC_DEF_STOP_OLD 2'h1
`define CSC_DEF_BAUD_NEW 16'h0060
`define CSC_DEF_BAUD_OLD 16'h0018

// Timing and cassette size
`define CSC_CLK_NS 50
`define CSC_ACCESS_NS 150
`define CSC_CAS_AW 14

`define CSC_RESP_OKAY 2'h0
`define CSC_RESP_SLVERR 2'h2

`endif

//--- pkg/csc_pkg.sv
package csc_pkg;
   typedef enum logic [1:0] {
      CSC_CP_IDLE = 2'b00,
      CSC_CP_READ = 2'b01,
      CSC_CP_DONE = 2'b10
   } csc_copy_type;

   typedef enum logic [2:0] {
      CSC_R_CTRL = 3'b000,
      CSC_R_STATUS = 3'b001,
      CSC_R_SETUP_RS = 3'b010,
      CSC_R_SETUP_PP = 3'b011,
      CSC_R_RS_CFG = 3'b100,
      CSC_R_PP_CFG = 3'b101,
      CSC_R_REJECTS = 3'b110,
      CSC_R_NONE = 3'b111
   } csc_reg_type;
endpackage : csc_pkg

//--- core/csc_switch_latch.sv
`timescale 1ns/1ps
module csc_switch_latch #(
   parameter int W = 10
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [W-1:0] sw_raw,
   output logic [W-1:0] sw_held,
   output logic held_valid
);
   logic [W-1:0] sw_q;
   logic valid_q;

   // One capture on the first edge after reset release
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sw_q <= '0;
         valid_q <= 1'b0;
      end else if (!valid_q) begin
         sw_q <= sw_raw;
         valid_q <= 1'b1;
      end
   end

   assign sw_held = sw_q;
   assign held_valid = valid_q;
endmodule : csc_switch_latch

//--- core/csc_serial_select.sv
`timescale 1ns/1ps
`include "csc_params.svh"
module csc_serial_select (
   input wire logic comm_default,
   input wire logic old_rev,
   input wire logic conv_cable,
   input wire logic console,
   input wire logic [31:0] setup_rs,
   input wire logic [31:0] setup_pp,
   output logic [31:0] rs_cfg,
   output logic [31:0] pp_cfg,
   output logic pp_default
);
   wire logic [1:0] stop_bits;
   wire logic [15:0] baud;
   wire logic [31:0] def_word;

   assign stop_bits = old_rev ? `CSC_DEF_STOP_OLD : `CSC_DEF_STOP_NEW;
   assign baud = old_rev ? `CSC_DEF_BAUD_OLD : `CSC_DEF_BAUD_NEW;
   assign def_word = {baud, `CSC_DEF_START, stop_bits,
                      `CSC_DEF_PARITY_EVEN, `CSC_DEF_DATA, `CSC_DEF_MODE};
   // Console on the peripheral port never takes defaults
   assign pp_default = comm_default & conv_cable & ~console;
   assign rs_cfg = comm_default ? def_word : setup_rs;
   assign pp_cfg = pp_default ? def_word : setup_pp;
endmodule : csc_serial_select

//--- core/csc_top.sv
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "csc_params.svh"
module csc_top #(
   parameter int DATA_W = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [5:0] dip_sw,
   input wire logic cas_present,
   input wire logic cas_eeprom,
   input wire logic cas_switch,
   input wire logic old_rev_strap,
   input wire logic conv_cable,
   input wire logic console_attached,
   input wire logic pw_valid,
   input wire logic pw_is_prog,
   input wire logic [15:0] pw_addr,
   output logic pw_ack,
   output logic pw_reject,
   output logic cas_rd,
   output logic [`CSC_CAS_AW-1:0] cas_addr,
   input wire logic [DATA_W-1:0] cas_rdata,
   output logic ram_wr,
   output logic [`CSC_CAS_AW-1:0] ram_addr,
   output logic [DATA_W-1:0] ram_wdata,
   output logic startup_done,
   output logic lang_english,
   output logic exp_user,
   output logic term_expanded,
   output logic [31:0] rs_cfg,
   output logic [31:0] pp_cfg,
   output logic pp_default
);
   import csc_pkg::*;
   localparam int ACC_CYC = (`CSC_ACCESS_NS + `CSC_CLK_NS - 1) / `CSC_CLK_NS;
   localparam logic [1:0] ACC_LAST = 2'(ACC_CYC - 1);
   localparam logic [`CSC_CAS_AW-1:0] CAS_LAST = '1;
   function automatic csc_reg_type reg_sel(input logic [7:0] a);
      case (a)
         `CSC_OFF_CTRL: reg_sel = CSC_R_CTRL;
         `CSC_OFF_STATUS: reg_sel = CSC_R_STATUS;
         `CSC_OFF_SETUP_RS: reg_sel = CSC_R_SETUP_RS;
         `CSC_OFF_SETUP_PP: reg_sel = CSC_R_SETUP_PP;
         `CSC_OFF_RS_CFG: reg_sel = CSC_R_RS_CFG;
         `CSC_OFF_PP_CFG: reg_sel = CSC_R_PP_CFG;
         `CSC_OFF_REJECTS: reg_sel = CSC_R_REJECTS;
         default: reg_sel = CSC_R_NONE;
      endcase
   endfunction : reg_sel
   function automatic logic [31:0] merge(input logic [31:0] old,
         input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) r[8*i +: 8] = nw[8*i +: 8];
      end
      merge = r;
   endfunction : merge
   // Held switches
   logic [`CSC_SW_W-1:0] sw;
   logic sw_valid;
   csc_switch_latch #(.W(`CSC_SW_W)) csc_switch_latch_inst (
      .aclk(aclk),
      .aresetn(aresetn),
      .sw_raw({old_rev_strap, cas_switch, cas_eeprom, cas_present, dip_sw}),
      .sw_held(sw),
      .held_valid(sw_valid)
   );
   // Bus state
   logic aw_got_q, w_got_q, awready_q, wready_q, bvalid_q;
   logic [1:0] bresp_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic arready_q, rvalid_q;
   logic [1:0] rresp_q;
   logic [31:0] rdata_q;
   // Block state
   logic aux_0709_q;
   logic [31:0] setup_rs_q, setup_pp_q;
   logic [15:0] rejects_q;
   csc_copy_type cp_q;
   logic [1:0] wait_q;
   logic cas_rd_q, ram_wr_q;
   logic [`CSC_CAS_AW-1:0] cas_addr_q, ram_addr_q;
   logic [DATA_W-1:0] ram_wdata_q;
   logic pw_ack_q, pw_reject_q, done_q;
   logic lang_q, exp_q, term_q;
   logic [31:0] rs_cfg_q, pp_cfg_q;
   logic pp_default_q;
   // Write channel decode
   wire logic aw_hs = awvalid & awready_q;
   wire logic w_hs = wvalid & wready_q;
   wire logic do_write = aw_got_q & w_got_q & ~bvalid_q;
   wire logic aw_got_d = (aw_got_q & ~do_write) | aw_hs;
   wire logic w_got_d = (w_got_q & ~do_write) | w_hs;
   wire logic bvalid_d = do_write | (bvalid_q & ~bready);
   wire csc_reg_type wsel = reg_sel(awaddr_q);
   wire logic wr_ctrl = do_write & (wsel == CSC_R_CTRL);
   wire logic wr_rs = do_write & (wsel == CSC_R_SETUP_RS);
   wire logic wr_pp = do_write & (wsel == CSC_R_SETUP_PP);
   // Read channel decode
   wire logic ar_hs = arvalid & arready_q;
   wire logic rvalid_d = ar_hs | (rvalid_q & ~rready);
   wire csc_reg_type rsel = reg_sel(araddr);
   wire logic [31:0] status_word = {16'h0000, 2'h0, term_q, pp_default_q,
      done_q, sw_valid, sw};
   wire logic [31:0] rd_mux =
      (rsel == CSC_R_CTRL) ? {31'h00000000, aux_0709_q} :
      (rsel == CSC_R_STATUS) ? status_word :
      (rsel == CSC_R_SETUP_RS) ? setup_rs_q :
      (rsel == CSC_R_SETUP_PP) ? setup_pp_q :
      (rsel == CSC_R_RS_CFG) ? rs_cfg_q :
      (rsel == CSC_R_PP_CFG) ? pp_cfg_q :
      (rsel == CSC_R_REJECTS) ? {16'h0000, rejects_q} : 32'h00000000;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= `CSC_RESP_OKAY;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
      end else begin
         aw_got_q <= aw_got_d;
         w_got_q <= w_got_d;
         awready_q <= ~aw_got_d & ~bvalid_d;
         wready_q <= ~w_got_d & ~bvalid_d;
         bvalid_q <= bvalid_d;
         if (aw_hs) awaddr_q <= awaddr;
         if (w_hs) begin
            wdata_q <= wdata;
            wstrb_q <= wstrb;
         end
         if (do_write) begin
            bresp_q <= (wsel == CSC_R_NONE) ? `CSC_RESP_SLVERR
                                            : `CSC_RESP_OKAY;
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rresp_q <= `CSC_RESP_OKAY;
         rdata_q <= 32'h00000000;
      end else begin
         arready_q <= ~rvalid_d;
         rvalid_q <= rvalid_d;
         if (ar_hs) begin
            rdata_q <= rd_mux;
            rresp_q <= (rsel == CSC_R_NONE) ? `CSC_RESP_SLVERR
                                            : `CSC_RESP_OKAY;
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aux_0709_q <= 1'b0;
         setup_rs_q <= 32'h00000000;
         setup_pp_q <= 32'h00000000;
      end else begin
         if (wr_ctrl && wstrb_q[0]) aux_0709_q <= wdata_q[0];
         if (wr_rs) setup_rs_q <= merge(setup_rs_q, wdata_q, wstrb_q);
         if (wr_pp) setup_pp_q <= merge(setup_pp_q, wdata_q, wstrb_q);
      end
   end
   // Peripheral write gate
   wire logic ro_word = ~pw_is_prog & (pw_addr >= `CSC_RO_LO)
      & (pw_addr <= `CSC_RO_HI);
   wire logic run_from_cas = sw[`CSC_SW_CAS_PRESENT] & ~sw[`CSC_SW_AUTO];
   wire logic cas_block = run_from_cas
      & (~sw[`CSC_SW_CAS_EEPROM] | sw[`CSC_SW_CAS_SWITCH]);
   wire logic prot_block = sw[`CSC_SW_PROTECT] & (pw_is_prog | ro_word);
   wire logic pw_block = ~done_q | prot_block | (pw_is_prog & cas_block);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pw_ack_q <= 1'b0;
         pw_reject_q <= 1'b0;
         rejects_q <= 16'h0000;
      end else begin
         pw_ack_q <= pw_valid & ~pw_block;
         pw_reject_q <= pw_valid & pw_block;
         if (pw_valid && pw_block) rejects_q <= rejects_q + 16'h0001;
      end
   end
   // Start-up cassette copy, one word per access time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cp_q <= CSC_CP_IDLE;
         wait_q <= 2'h0;
         cas_rd_q <= 1'b0;
         cas_addr_q <= '0;
         ram_wr_q <= 1'b0;
         ram_addr_q <= '0;
         ram_wdata_q <= '0;
         done_q <= 1'b0;
      end else begin
         ram_wr_q <= 1'b0;
         unique case (cp_q)
            CSC_CP_IDLE: begin
               if (sw_valid) begin
                  if (sw[`CSC_SW_AUTO] && sw[`CSC_SW_CAS_PRESENT]) begin
                     cp_q <= CSC_CP_READ;
                     cas_rd_q <= 1'b1;
                     cas_addr_q <= '0;
                     wait_q <= 2'h0;
                  end else begin
                     cp_q <= CSC_CP_DONE;
                     done_q <= 1'b1;
                  end
               end
            end
            CSC_CP_READ: begin
               if (wait_q == ACC_LAST) begin
                  ram_wr_q <= 1'b1;
                  ram_addr_q <= cas_addr_q;
                  ram_wdata_q <= cas_rdata;
                  wait_q <= 2'h0;
                  if (cas_addr_q == CAS_LAST) begin
                     cp_q <= CSC_CP_DONE;
                     cas_rd_q <= 1'b0;
                     done_q <= 1'b1;
                  end else begin
                     cas_addr_q <= cas_addr_q + 1'b1;
                  end
               end else begin
                  wait_q <= wait_q + 2'h1;
               end
            end
            CSC_CP_DONE: done_q <= 1'b1;
            default: cp_q <= CSC_CP_IDLE;
         endcase
      end
   end
   // Settings decoded from held switches
   wire logic [31:0] rs_cfg_c, pp_cfg_c;
   wire logic pp_default_c;
   csc_serial_select csc_serial_select_inst (
      .comm_default(sw[`CSC_SW_COMM]),
      .old_rev(sw[`CSC_SW_OLD_REV]),
      .conv_cable(conv_cable),
      .console(console_attached),
      .setup_rs(setup_rs_q),
      .setup_pp(setup_pp_q),
      .rs_cfg(rs_cfg_c),
      .pp_cfg(pp_cfg_c),
      .pp_default(pp_default_c)
   );
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lang_q <= 1'b0;
         exp_q <= 1'b0;
         term_q <= 1'b0;
         rs_cfg_q <= 32'h00000000;
         pp_cfg_q <= 32'h00000000;
         pp_default_q <= 1'b0;
      end else begin
         lang_q <= sw_valid & sw[`CSC_SW_LANG];
         exp_q <= sw_valid & sw[`CSC_SW_EXP];
         term_q <= sw_valid & aux_0709_q & sw[`CSC_SW_TERM];
         rs_cfg_q <= rs_cfg_c;
         pp_cfg_q <= pp_cfg_c;
         pp_default_q <= pp_default_c;
      end
   end
   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rresp = rresp_q;
   assign rdata = rdata_q;
   assign pw_ack = pw_ack_q;
   assign pw_reject = pw_reject_q;
   assign cas_rd = cas_rd_q;
   assign cas_addr = cas_addr_q;
   assign ram_wr = ram_wr_q;
   assign ram_addr = ram_addr_q;
   assign ram_wdata = ram_wdata_q;
   assign startup_done = done_q;
   assign lang_english = lang_q;
   assign exp_user = exp_q;
   assign term_expanded = term_q;
   assign rs_cfg = rs_cfg_q;
   assign pp_cfg = pp_cfg_q;
   assign pp_default = pp_default_q;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_PROT_ON: assert property (
      pw_valid && pw_is_prog && done_q && sw[`CSC_SW_PROTECT]
      |=> pw_reject_q && !pw_ack_q)
      else $error("protected program write accepted");
   AST_PROT_OFF: assert property (
      pw_valid && ro_word && done_q && !sw[`CSC_SW_PROTECT]
      |=> pw_ack_q)
      else $error("unprotected setup word write refused");
   AST_NO_COPY: assert property (
      sw_valid && !sw[`CSC_SW_AUTO] |-> !ram_wr_q && !cas_rd_q)
      else $error("copy ran with auto transfer off");
   AST_COPY_PACE: assert property (
      ram_wr_q |=> !ram_wr_q ##1 !ram_wr_q)
      else $error("cassette word faster than access time");
   AST_LANG_HELD: assert property (
      sw_valid && $past(sw_valid) |=> $stable(lang_q) && $stable(exp_q))
      else $error("held setting changed after capture");
   AST_TERM: assert property (
      sw_valid && aux_0709_q && sw[`CSC_SW_TERM] |=> term_q)
      else $error("expanded terminal bit not set");
   AST_SER_DEF: assert property (
      sw_valid && sw[`CSC_SW_COMM] && !sw[`CSC_SW_OLD_REV]
      |=> rs_cfg_q[31:16] == `CSC_DEF_BAUD_NEW
          && rs_cfg_q[11:10] == `CSC_DEF_STOP_NEW)
      else $error("default serial word wrong");
   AST_SER_OLD: assert property (
      sw_valid && sw[`CSC_SW_COMM] && sw[`CSC_SW_OLD_REV]
      |=> rs_cfg_q[31:16] == `CSC_DEF_BAUD_OLD
          && rs_cfg_q[11:10] == `CSC_DEF_STOP_OLD)
      else $error("older revision defaults wrong");
   AST_SER_SETUP: assert property (
      sw_valid && !sw[`CSC_SW_COMM] |=> rs_cfg_q == $past(setup_rs_q))
      else $error("setup words not used");
   AST_CAS_WP: assert property (
      pw_valid && pw_is_prog && done_q && run_from_cas
      && sw[`CSC_SW_CAS_SWITCH] |=> pw_reject_q)
      else $error("write-protected cassette overwritten");
   AST_OTP: assert property (
      pw_valid && pw_is_prog && done_q && run_from_cas
      && !sw[`CSC_SW_CAS_EEPROM] |=> pw_reject_q)
      else $error("one-time cassette written");
endmodule : csc_top

//--- testbench/csc_cassette_model.sv
`timescale 1ns/1ps
`include "csc_params.svh"
module csc_cassette_model #(
   parameter int LAT = 0
) (
   input wire logic aclk,
   input wire logic cas_rd,
   input wire logic [`CSC_CAS_AW-1:0] cas_addr,
   output logic [15:0] cas_rdata
);
   logic [15:0] last_q = 16'h0000;
   logic [`CSC_CAS_AW-1:0] addr_q = '0;
   int age_q = 0;
   always @(posedge aclk) begin
      addr_q <= cas_addr;
      age_q <= (cas_addr != addr_q) ? 0 : age_q + 1;
      last_q <= cas_rdata;
   end
   // Only 16K words reach the chip; data toggles when not driven
   assign cas_rdata = (cas_rd && age_q >= LAT) ?
      {cas_addr[7:0], ~cas_addr[13:6]} : ~last_q;
endmodule : csc_cassette_model

//--- testbench/csc_top_tb.sv
`timescale 1ns/1ps
`include "csc_params.svh"
module csc_top_tb;
   localparam int LIMIT = 70000;
   localparam logic [31:0] DEF_NEW = {16'h0060, 4'h1, 2'h2, 2'h2, 4'h7, 4'h0};
   localparam logic [31:0] DEF_OLD = {16'h0018, 4'h1, 2'h1, 2'h2, 4'h7, 4'h0};
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, rs_cfg, pp_cfg;
   logic [5:0] dip_sw = 6'h00;
   logic cas_present = 1'b0, cas_eeprom = 1'b0, cas_switch = 1'b0;
   logic old_rev_strap = 1'b0, conv_cable = 1'b0, console_attached = 1'b0;
   logic pw_valid = 1'b0, pw_is_prog = 1'b0;
   logic [15:0] pw_addr = 16'h0000;
   logic pw_ack, pw_reject, cas_rd, ram_wr, startup_done;
   logic lang_english, exp_user, term_expanded, pp_default;
   logic [13:0] cas_addr, ram_addr;
   logic [15:0] cas_rdata, ram_wdata;
   int err_total = 0, n_tests = 0, cyc = 0, n_wr = 0;

   csc_top csc_top_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready,
      .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .dip_sw,
      .cas_present, .cas_eeprom, .cas_switch, .old_rev_strap, .conv_cable,
      .console_attached, .pw_valid, .pw_is_prog, .pw_addr, .pw_ack,
      .pw_reject, .cas_rd, .cas_addr, .cas_rdata, .ram_wr, .ram_addr,
      .ram_wdata, .startup_done, .lang_english, .exp_user, .term_expanded,
      .rs_cfg, .pp_cfg, .pp_default);
   csc_cassette_model #(.LAT(1)) csc_cassette_model_inst (.aclk,
      .cas_rd, .cas_addr, .cas_rdata);

   always #25 aclk = ~aclk;

   task automatic check(input string what, input logic [31:0] seen,
         input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic summarize;
      $display("Checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : summarize

   // Switches move right after capture to show they are held
   task automatic boot(input logic [5:0] d, input logic [3:0] cas);
      @(posedge aclk);
      aresetn <= 1'b0;
      dip_sw <= d;
      {cas_present, cas_eeprom, cas_switch, old_rev_strap} <= cas;
      repeat (8) @(posedge aclk);
      n_wr = 0;
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      dip_sw <= ~d;
   endtask : boot

   task automatic done_wait;
      while (startup_done !== 1'b1) @(posedge aclk);
      // Let the last copy word be counted first
      @(posedge aclk);
   endtask : done_wait

   task automatic pw(input logic p, input logic [15:0] a,
         input logic [1:0] exp);
      @(posedge aclk);
      pw_valid <= 1'b1;
      pw_is_prog <= p;
      pw_addr <= a;
      @(posedge aclk);
      pw_valid <= 1'b0;
      @(posedge aclk);
      check("ack rej", {30'h0, pw_ack, pw_reject}, {30'h0, exp});
   endtask : pw

   task automatic axw(input logic [7:0] a, input logic [31:0] d,
         input logic [1:0] er);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (!aw_ok && awready === 1'b1) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready === 1'b1) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1) @(posedge aclk);
      bready <= 1'b0;
      check("bresp", {30'h0, bresp}, {30'h0, er});
   endtask : axw

   task automatic rdchk(input logic [7:0] a, input logic [31:0] ed,
         input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge aclk);
      rready <= 1'b0;
      check("rdata", rdata, ed);
      check("rresp", {30'h0, rresp}, {30'h0, er});
   endtask : rdchk

   always @(posedge aclk) begin
      cyc++;
      if (ram_wr === 1'b1) begin
         check("copy addr", {18'h0, ram_addr}, {18'h0, n_wr[13:0]});
         check("copy data", {16'h0, ram_wdata},
            {16'h0, ram_addr[7:0], ~ram_addr[13:6]});
         n_wr++;
      end
      if (cyc == LIMIT) begin
         err_total++;
         summarize();
      end
   end

   initial begin
      // No cassette; lang, exp, comm, term on
      boot(6'b111100, 4'b0000);
      done_wait();
      check("lang", lang_english, 1'b1);
      check("exp", exp_user, 1'b1);
      check("rs cfg", rs_cfg, DEF_NEW);
      check("no copy", n_wr, 0);
      conv_cable <= 1'b1;
      repeat (2) @(posedge aclk);
      check("pp dflt", pp_default, 1'b1);
      check("pp cfg", pp_cfg, DEF_NEW);
      console_attached <= 1'b1;
      repeat (2) @(posedge aclk);
      check("pp console", pp_default, 1'b0);
      pw(1'b1, 16'h0000, 2'b10);
      pw(1'b0, 16'h1800, 2'b10);
      pw(1'b0, 16'h19ff, 2'b10);
      axw(`CSC_OFF_CTRL, 32'h1, `CSC_RESP_OKAY);
      repeat (2) @(posedge aclk);
      check("term on", term_expanded, 1'b1);
      axw(`CSC_OFF_CTRL, 32'h0, `CSC_RESP_OKAY);
      repeat (2) @(posedge aclk);
      check("term off", term_expanded, 1'b0);
      rdchk(`CSC_OFF_STATUS, 32'h0000_0c3c, `CSC_RESP_OKAY);
      rdchk(8'h1c, 32'h0, `CSC_RESP_SLVERR);
      axw(`CSC_OFF_RS_CFG, 32'h1234_5678, `CSC_RESP_OKAY);
      rdchk(`CSC_OFF_RS_CFG, DEF_NEW, `CSC_RESP_OKAY);
      $display("Test defaults done");
      // Protect, auto copy, comm off
      console_attached <= 1'b0;
      boot(6'b000011, 4'b1101);
      pw(1'b0, 16'h0000, 2'b01);
      check("lang off", lang_english, 1'b0);
      check("exp off", exp_user, 1'b0);
      done_wait();
      check("copy count", n_wr, 16384);
      pw(1'b1, 16'h0000, 2'b01);
      pw(1'b0, 16'h1800, 2'b01);
      pw(1'b0, 16'h19ff, 2'b01);
      pw(1'b0, 16'h17ff, 2'b10);
      pw(1'b0, 16'h1a00, 2'b10);
      rdchk(`CSC_OFF_REJECTS, 32'h4, `CSC_RESP_OKAY);
      axw(`CSC_OFF_SETUP_RS, 32'h0003_8e21, `CSC_RESP_OKAY);
      axw(`CSC_OFF_SETUP_PP, 32'h5a5a_1000, `CSC_RESP_OKAY);
      repeat (2) @(posedge aclk);
      check("rs setup", rs_cfg, 32'h0003_8e21);
      check("pp setup", pp_cfg, 32'h5a5a_1000);
      check("pp setup dflt", pp_default, 1'b0);
      wstrb <= 4'h3;
      axw(`CSC_OFF_SETUP_RS, 32'hffff_0000, `CSC_RESP_OKAY);
      wstrb <= 4'hf;
      rdchk(`CSC_OFF_SETUP_RS, 32'h0003_0000, `CSC_RESP_OKAY);
      axw(`CSC_OFF_CTRL, 32'h1, `CSC_RESP_OKAY);
      repeat (2) @(posedge aclk);
      check("term sw off", term_expanded, 1'b0);
      $display("Test copy done");
      // One-time cassette run in place, older revision
      boot(6'b010000, 4'b1001);
      done_wait();
      check("old dflt", rs_cfg, DEF_OLD);
      pw(1'b1, 16'h0000, 2'b01);
      pw(1'b0, 16'h1800, 2'b10);
      $display("Test one-time done");
      // Rewritable cassette, write-protect off then on
      for (int wp = 0; wp < 2; wp++) begin
         boot(6'b000000, {2'b11, wp[0], 1'b0});
         done_wait();
         pw(1'b1, 16'h0000, wp[0] ? 2'b01 : 2'b10);
      end
      $display("Test rewritable done");
      summarize();
   end
endmodule : csc_top_tb
